/* core/arr_map.svh */
`ifndef ARR_MAP_SVH
`define ARR_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ARR_OFS_CTRL1 8'h00
`define ARR_OFS_CTRL2 8'h01
`define ARR_OFS_CTRL3 8'h02
`define ARR_OFS_STAT1 8'h03
`define ARR_OFS_STAT2 8'h04
`define ARR_OFS_DATA 8'h05
`define ARR_OFS_DIV 8'h06

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ARR_C1_LEN9 4
`define ARR_C1_WAKE_ADDR 3
`define ARR_C1_QUIET_TYPE 2
`define ARR_C1_PAR_EN 1
`define ARR_C1_PAR_ODD 0
`define ARR_C2_FULL_IE 5
`define ARR_C2_QUIET_IE 4
`define ARR_C2_STANDBY 1
`define ARR_C3_R8 7
`define ARR_C3_OVR_IE 3
`define ARR_C3_NOISE_IE 2
`define ARR_C3_FRAME_IE 1
`define ARR_C3_PAR_IE 0
`define ARR_S1_FULL 5
`define ARR_S1_QUIET 4
`define ARR_S1_OVR 3
`define ARR_S1_NOISE 2
`define ARR_S1_FRAME 1
`define ARR_S1_PAR 0
`define ARR_S2_BREAK 1
`define ARR_S2_BUSY 0

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define ARR_RST_BYTE 8'h00
`define ARR_RST_DIV 8'hA2
`define ARR_OVERSAMPLE 5'h10
`define ARR_RT_S1 5'h03
`define ARR_RT_S2 5'h05
`define ARR_RT_S3 5'h07
`define ARR_RT_D1 5'h08
`define ARR_RT_D2 5'h09
`define ARR_RT_D3 5'h0A
`define ARR_REALIGN_BASE 5'h0C
`define ARR_QUIET_8 4'hA
`define ARR_QUIET_9 4'hB
`define ARR_LAST_BIT_8 4'h7
`define ARR_LAST_BIT_9 4'h8

`endif

/* core/arr_pkg.sv */
package arr_pkg;
    typedef enum logic [1:0] {
        ARR_SEARCH = 2'b00,
        ARR_START = 2'b01,
        ARR_DATA = 2'b11,
        ARR_STOP = 2'b10
    } arr_state_t;
endpackage

/* core/arr_rx.sv */
//
// Overview of operation
// (R1) sample input at sixteen slots per bit
// (R2) realign phase after start and falling data bit
// (R3) start search: zero after three ones
// (R4) start verified by slots three, five, seven
// (R5) failed verification restarts the start search
// (R6) data bit is majority of slots 8-10
// (R7) stop majority zero gives framing error, noise
// (R8) framing error with full flag; break too
// (R9) start slots 8-10 ones only set noise
// (R10) standby bit suppresses receiver interrupts
// (R11) address mark wakes, sets full flag
// (R12) idle wake sets neither idle nor full
// (R13) clearing wake method may wake immediately
// (R14) full flag on buffer load, gated interrupt
// (R15) idle after 10/11 ones, gated interrupt
// (R16) overrun keeps old data, drops new
// (R17) noise in any bit sets noise flag
// (R18) framing and parity errors separately enabled
// (R19) wait mode: runs, bus blocked, irq wakes
// (R20) stop mode halts, keeps registers, drops character
// (R21) break with clear enable lets clears stick
// (R22) break without clear enable freezes flags
// (R23) length bit selects eight or nine data bits
// (R24) quiet type: count after stop or start
// (R25) interrupt outputs are ORed gated flags
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "arr_map.svh"
module arr_rx
    import arr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // line
    input wire logic serial_input_pin_in,
    // system mode and debug break
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic break_state_in,
    input wire logic break_clear_enable_in,
    // interrupt requests
    output logic rx_irq_out,
    output logic err_irq_out
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [7:0] control_one_r;
    logic [7:0] control_two_r;
    logic [3:0] control_three_r;
    logic [7:0] div_r;
    logic [7:0] receive_data_buffer_r;
    logic r8_r;
    logic [5:0] status_one_r;
    logic brk_flag_r;
    logic [6:0] armed_r;
    logic standby_r;
    arr_state_t state_r;
    logic [4:0] rt_r;
    logic [3:0] bit_cnt_r;
    logic [8:0] shift_r;
    logic [1:0] samp_r;
    logic noise_r;
    logic prev_bit_r;
    logic edge_seen_r;
    logic [4:0] edge_rt_r;
    logic rx_s_r;
    logic [2:0] hist_r;
    logic [3:0] ones_r;
    logic [3:0] sub_r;
    logic tick;
    logic vmaj;
    logic vnoise;
    logic len9;
    logic wake_addr;
    logic acc_ok;
    logic cpu_ok;
    logic blocked;
    logic wr_ok;
    logic rd_ok;
    logic [3:0] quiet_thr;
    logic [3:0] last_bit;
    logic start_hit;
    logic stop_done;
    logic [8:0] char9;
    logic msb;
    logic fe_evt;
    logic noise_evt;
    logic pe_evt;
    logic brk_evt;
    logic accept;
    logic load_evt;
    logic ovr_evt;
    logic quiet_evt;
    logic line_quiet;
    logic idle_wake;
    logic [6:0] clr_mask;

    // ---------------------------------------------------------------
    // control decode
    // ---------------------------------------------------------------
    assign len9 = control_one_r[`ARR_C1_LEN9];
    assign wake_addr = control_one_r[`ARR_C1_WAKE_ADDR];
    assign quiet_thr = len9 ? `ARR_QUIET_9 : `ARR_QUIET_8; // R15
    assign last_bit = len9 ? `ARR_LAST_BIT_9 : `ARR_LAST_BIT_8; // R23
    // bus is dead while the cpu sleeps in wait
    assign cpu_ok = ~wait_mode_in; // R19
    assign wr_ok = wr_in & cpu_ok;
    assign rd_ok = rd_in & cpu_ok;
    // flags frozen by a debug break unless clears are allowed
    assign blocked = break_state_in & ~break_clear_enable_in; // R22

    // ---------------------------------------------------------------
    // oversample timebase and voter
    // ---------------------------------------------------------------
    arr_tick u_tick (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .run_in(~stop_mode_in), // R20
        .div_in(div_r),
        .tick_out(tick) // R1
    );

    arr_vote u_vote (
        .samp_in({samp_r, rx_s_r}),
        .maj_out(vmaj),
        .noise_out(vnoise)
    );

    // ---------------------------------------------------------------
    // frame events
    // ---------------------------------------------------------------
    assign start_hit = tick & (state_r == ARR_SEARCH) & ~rx_s_r & (&hist_r); // R3
    assign stop_done = tick & ~stop_mode_in & (state_r == ARR_STOP) & (rt_r == `ARR_RT_D3);
    assign char9 = len9 ? shift_r : {1'b0, shift_r[8:1]};
    assign msb = len9 ? char9[8] : char9[7];
    assign fe_evt = ~vmaj; // R7
    assign noise_evt = noise_r | vnoise; // R17
    assign pe_evt = control_one_r[`ARR_C1_PAR_EN] &
                    ((^char9) != control_one_r[`ARR_C1_PAR_ODD]);
    assign brk_evt = fe_evt & (char9 == 9'h000); // R8
    assign acc_ok = ~standby_r | (wake_addr & msb); // R11
    assign accept = stop_done & acc_ok;
    assign ovr_evt = accept & status_one_r[`ARR_S1_FULL]; // R16
    assign load_evt = accept & ~status_one_r[`ARR_S1_FULL]; // R14
    assign quiet_evt = tick & ~stop_mode_in & (state_r == ARR_SEARCH) & rx_s_r &
                       (sub_r == 4'hF) & (ones_r == quiet_thr - 4'h1); // R15
    assign line_quiet = ones_r >= quiet_thr;
    // a quiet line already present wakes as soon as idle wake is chosen
    assign idle_wake = standby_r & ~wake_addr & (quiet_evt | line_quiet); // R12 R13

    // ---------------------------------------------------------------
    // line sampling
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rx_s_r <= 1'b1;
            hist_r <= 3'h0;
        end else begin
            rx_s_r <= serial_input_pin_in;
            if (tick) begin
                hist_r <= {hist_r[1:0], rx_s_r};
            end
        end
    end

    // ---------------------------------------------------------------
    // recovery state machine
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_r <= ARR_SEARCH;
            rt_r <= 5'h00;
            bit_cnt_r <= 4'h0;
            shift_r <= 9'h000;
            samp_r <= 2'h0;
            noise_r <= 1'b0;
            prev_bit_r <= 1'b0;
            edge_seen_r <= 1'b0;
            edge_rt_r <= 5'h00;
        end else if (stop_mode_in) begin
            state_r <= ARR_SEARCH; // R20
            rt_r <= 5'h00;
        end else if (tick) begin
            unique case (state_r)
                ARR_SEARCH: begin
                    if (start_hit) begin
                        state_r <= ARR_START;
                        rt_r <= 5'h02; // R3
                        noise_r <= 1'b0;
                    end
                end
                ARR_START: begin
                    rt_r <= rt_r + 5'h01;
                    if (rt_r == `ARR_RT_S1 || rt_r == `ARR_RT_S2 ||
                        rt_r == `ARR_RT_D1 || rt_r == `ARR_RT_D2) begin
                        samp_r <= {samp_r[0], rx_s_r};
                    end
                    if (rt_r == `ARR_RT_S3) begin
                        if (vmaj) begin
                            state_r <= ARR_SEARCH; // R5
                            rt_r <= 5'h00;
                        end else begin
                            noise_r <= vnoise; // R4
                        end
                    end
                    if (rt_r == `ARR_RT_D3 && (|{samp_r, rx_s_r})) begin
                        noise_r <= 1'b1; // R9
                    end
                    if (rt_r == `ARR_OVERSAMPLE) begin
                        state_r <= ARR_DATA;
                        rt_r <= 5'h01;
                        bit_cnt_r <= 4'h0;
                        prev_bit_r <= 1'b0;
                        edge_seen_r <= 1'b0;
                    end
                end
                ARR_DATA: begin
                    rt_r <= rt_r + 5'h01;
                    if (prev_bit_r && !edge_seen_r && rt_r <= `ARR_RT_D3 &&
                        !rx_s_r && hist_r[0]) begin
                        edge_seen_r <= 1'b1;
                        edge_rt_r <= rt_r;
                    end
                    if (rt_r == `ARR_RT_D1 || rt_r == `ARR_RT_D2) begin
                        samp_r <= {samp_r[0], rx_s_r};
                    end
                    if (rt_r == `ARR_RT_D3) begin
                        shift_r <= {vmaj, shift_r[8:1]}; // R6
                        noise_r <= noise_r | vnoise; // R6
                        prev_bit_r <= vmaj;
                        // one-to-zero change: pull the phase onto the edge seen
                        if (prev_bit_r && !vmaj && edge_seen_r) begin
                            rt_r <= `ARR_REALIGN_BASE - edge_rt_r; // R2
                        end
                    end
                    if (rt_r == `ARR_OVERSAMPLE) begin
                        rt_r <= 5'h01;
                        edge_seen_r <= 1'b0;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == last_bit) begin
                            state_r <= ARR_STOP; // R23
                        end
                    end
                end
                ARR_STOP: begin
                    rt_r <= rt_r + 5'h01;
                    if (rt_r == `ARR_RT_D1 || rt_r == `ARR_RT_D2) begin
                        samp_r <= {samp_r[0], rx_s_r};
                    end
                    if (rt_r == `ARR_RT_D3) begin
                        state_r <= ARR_SEARCH; // R7
                        rt_r <= 5'h00;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // quiet line counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ones_r <= 4'h0;
            sub_r <= 4'h0;
        end else if (stop_mode_in) begin
            sub_r <= 4'h0;
        end else if (tick) begin
            if (state_r == ARR_SEARCH) begin
                if (!rx_s_r) begin
                    ones_r <= 4'h0;
                    sub_r <= 4'h0;
                end else begin
                    sub_r <= sub_r + 4'h1;
                    if (sub_r == 4'hF && !line_quiet) begin
                        ones_r <= ones_r + 4'h1; // R15
                    end
                end
            end else if (state_r == ARR_START) begin
                ones_r <= 4'h0;
                sub_r <= 4'h0;
            end else if (rt_r == `ARR_RT_D3) begin
                // counting from the start bit risks a false idle on 1-rich data
                if (!control_one_r[`ARR_C1_QUIET_TYPE] && vmaj) begin
                    ones_r <= ones_r + 4'h1; // R24
                end else begin
                    ones_r <= 4'h0; // R24
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // control registers and standby
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            control_one_r <= `ARR_RST_BYTE;
            control_two_r <= `ARR_RST_BYTE;
            control_three_r <= 4'h0;
            div_r <= `ARR_RST_DIV;
        end else if (wr_ok) begin
            unique case (addr_in)
                `ARR_OFS_CTRL1: control_one_r <= wr_data_in;
                `ARR_OFS_CTRL2: control_two_r <= wr_data_in;
                `ARR_OFS_CTRL3: control_three_r <= wr_data_in[3:0];
                `ARR_OFS_DIV: div_r <= wr_data_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            standby_r <= 1'b0;
        end else if ((stop_done && standby_r && wake_addr && msb) || idle_wake) begin
            standby_r <= 1'b0; // R11 R12
        end else if (wr_ok && addr_in == `ARR_OFS_CTRL2) begin
            standby_r <= wr_data_in[`ARR_C2_STANDBY]; // R10
        end
    end

    // ---------------------------------------------------------------
    // receive buffer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            receive_data_buffer_r <= `ARR_RST_BYTE;
            r8_r <= 1'b0;
        end else if (load_evt) begin
            receive_data_buffer_r <= char9[7:0]; // R14
            r8_r <= msb;
        end
    end

    // ---------------------------------------------------------------
    // status flags with two-step clear
    // ---------------------------------------------------------------
    // a status-one read arms its flags and the break flag; the buffer read clears them
    assign clr_mask = (rd_ok && !blocked && addr_in == `ARR_OFS_DATA) ? armed_r : 7'h00;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            armed_r <= 7'h00;
        end else if (rd_ok && !blocked) begin // R21 R22
            if (addr_in == `ARR_OFS_STAT1) begin
                armed_r <= {brk_flag_r, status_one_r};
            end else if (addr_in == `ARR_OFS_DATA) begin
                armed_r <= 7'h00;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            status_one_r <= 6'h00;
            brk_flag_r <= 1'b0;
        end else begin
            // new events win over a clear in the same cycle
            status_one_r[`ARR_S1_FULL] <= load_evt |
                (status_one_r[`ARR_S1_FULL] & ~clr_mask[`ARR_S1_FULL]); // R14
            status_one_r[`ARR_S1_QUIET] <= (quiet_evt & ~(standby_r & ~wake_addr)) |
                (status_one_r[`ARR_S1_QUIET] & ~clr_mask[`ARR_S1_QUIET]); // R12 R15
            status_one_r[`ARR_S1_OVR] <= ovr_evt |
                (status_one_r[`ARR_S1_OVR] & ~clr_mask[`ARR_S1_OVR]); // R16
            status_one_r[`ARR_S1_NOISE] <= (load_evt & noise_evt) |
                (status_one_r[`ARR_S1_NOISE] & ~clr_mask[`ARR_S1_NOISE]); // R17
            status_one_r[`ARR_S1_FRAME] <= (load_evt & fe_evt) |
                (status_one_r[`ARR_S1_FRAME] & ~clr_mask[`ARR_S1_FRAME]); // R8
            status_one_r[`ARR_S1_PAR] <= (load_evt & pe_evt) |
                (status_one_r[`ARR_S1_PAR] & ~clr_mask[`ARR_S1_PAR]); // R18
            brk_flag_r <= (load_evt & brk_evt) | (brk_flag_r & ~clr_mask[6]); // R8
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_ok) begin
            unique case (addr_in)
                `ARR_OFS_CTRL1: rd_data_out <= control_one_r;
                `ARR_OFS_CTRL2: rd_data_out <= {control_two_r[7:2], standby_r,
                                                control_two_r[0]};
                `ARR_OFS_CTRL3: rd_data_out <= {r8_r, 3'h0, control_three_r};
                `ARR_OFS_STAT1: rd_data_out <= {2'h0, status_one_r};
                `ARR_OFS_STAT2: rd_data_out <= {6'h00, brk_flag_r,
                                                state_r != ARR_SEARCH};
                `ARR_OFS_DATA: rd_data_out <= receive_data_buffer_r;
                `ARR_OFS_DIV: rd_data_out <= div_r;
                default: rd_data_out <= 8'h00;
            endcase
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // interrupt requests
    // ---------------------------------------------------------------
    // levels, so they also serve as the wakeup from wait
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rx_irq_out <= 1'b0;
            err_irq_out <= 1'b0;
        end else begin
            rx_irq_out <= ~standby_r & // R10 R25
                ((status_one_r[`ARR_S1_FULL] & control_two_r[`ARR_C2_FULL_IE]) |
                 (status_one_r[`ARR_S1_QUIET] & control_two_r[`ARR_C2_QUIET_IE])); // R19
            err_irq_out <= // R25
                (status_one_r[`ARR_S1_OVR] & control_three_r[`ARR_C3_OVR_IE]) |
                (status_one_r[`ARR_S1_NOISE] & control_three_r[`ARR_C3_NOISE_IE]) |
                (status_one_r[`ARR_S1_FRAME] & control_three_r[`ARR_C3_FRAME_IE]) |
                (status_one_r[`ARR_S1_PAR] & control_three_r[`ARR_C3_PAR_IE]); // R18
        end
    end
endmodule
`default_nettype wire

/* core/arr_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module arr_tick (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // control
    input wire logic run_in,
    input wire logic [7:0] div_in,
    // oversample enable pulse
    output logic tick_out
);
    logic [7:0] cnt_r;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_r <= 8'h00;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_r <= 8'h00;
            tick_out <= 1'b0;
        end else if (cnt_r >= div_in) begin
            cnt_r <= 8'h00;
            tick_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* core/arr_vote.sv */
`timescale 1ns/10ps
`default_nettype none
module arr_vote (
    // three samples
    input wire logic [2:0] samp_in,
    // results
    output logic maj_out,
    output logic noise_out
);
    assign maj_out = (samp_in[2] & samp_in[1]) | (samp_in[2] & samp_in[0]) |
                     (samp_in[1] & samp_in[0]);
    assign noise_out = (|samp_in) & ~(&samp_in);
endmodule
`default_nettype wire

/* dv/arr_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
module arr_line_model #(
    parameter int BIT = 32
) (
    // clock
    input wire logic clk_in,
    // line toward the receiver, idle high
    output logic line_out
);
    initial line_out = 1'b1;
    // lsb first; bit g flipped two clocks from go
    task automatic send(input logic [11:0] f, input int n, g, go);
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < BIT; c++) begin
                @(posedge clk_in);
                line_out <= f[i] ^ (i == g && c >= go && c <= go + 1);
            end
        end
        @(posedge clk_in);
        line_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* dv/arr_rx_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module arr_rx_monitor (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    // modes and requests
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic rx_irq_out,
    input wire logic err_irq_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence wr_at(a);
        wr_in && !wait_mode_in && addr_in == a;
    endsequence
    sequence rd_at(a);
        rd_in && !wait_mode_in && addr_in == a;
    endsequence
    a_idle_read_zero: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
        else $error("read data outside its slot");
    a_wait_read_blank: assert property (rd_in && wait_mode_in |=> rd_data_out == 8'h00)
        else $error("read taken in wait mode");
    a_standby_mutes_rx: assert property (wr_at(8'h01) ##0 wr_data_in[1] |-> ##2 !rx_irq_out)
        else $error("rx request in standby");
    a_rx_ie_off: assert property (wr_at(8'h01) ##0 wr_data_in[5:4] == 2'b00 |-> ##2 !rx_irq_out)
        else $error("rx request without enable");
    a_err_ie_off: assert property (wr_at(8'h02) ##0 wr_data_in[3:0] == 4'h0 |-> ##2 !err_irq_out)
        else $error("error request without enable");
    a_stop_freezes_irq: assert property ((stop_mode_in && !wr_in && !rd_in) [*3] |->
        $stable(rx_irq_out) && $stable(err_irq_out)) else $error("request moved in stop");
    a_ctrl2_ie_echo: assert property (wr_at(8'h01) ##1 rd_at(8'h01) |=>
        (rd_data_out & 8'h30) == ($past(wr_data_in, 2) & 8'h30)) else $error("enable lost");
    a_ctrl3_ie_echo: assert property (wr_at(8'h02) ##1 rd_at(8'h02) |=>
        rd_data_out[3:0] == $past(wr_data_in[3:0], 2)) else $error("error enable lost");
endmodule
bind arr_rx arr_rx_monitor arr_rx_monitor_i (.*);
`default_nettype wire

/* dv/arr_rx_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected %0t got %h want %h", $time, a, e); end end
module arr_rx_tb_top;
    logic clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic wt = 1'b0, sp = 1'b0, br = 1'b0, bce = 1'b0;
    logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out, v, d;
    logic line, rx_irq_out, err_irq_out;
    logic [31:0] seed = 32'h00002E0E;
    int n_mismatch = 0, compares = 0;
    always #20 clk_in = ~clk_in;
    arr_rx arr_rx_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .serial_input_pin_in(line), .wait_mode_in(wt), .stop_mode_in(sp),
        .break_state_in(br), .break_clear_enable_in(bce), .rx_irq_out(rx_irq_out),
        .err_irq_out(err_irq_out));
    // divisor 1: 32 clocks a bit
    arr_line_model #(.BIT(32)) arr_line_model_i (.clk_in(clk_in), .line_out(line));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] st(logic fu, ov, no, fr);
        return {2'b00, fu, 1'b0, ov, no, fr, 1'b0};
    endfunction
    task automatic wr(input logic [7:0] a, x);
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        addr_in <= a;
        wr_data_in <= x;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        rd_in <= 1'b1;
        wr_in <= 1'b0;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        x = rd_data_out;
    endtask
    task automatic nop(input int n);
        wr_in <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic tx(input logic [8:0] x, input logic nine, stp, input int g);
        logic [11:0] f;
        f = {2'b11, x, 1'b0};
        f[nine ? 10 : 9] = stp;
        wr_in <= 1'b0;
        // two clocks hit one vote slot
        arr_line_model_i.send(f, nine ? 11 : 10, g, 17);
        repeat (4) @(posedge clk_in);
    endtask
    task automatic chr(input logic [7:0] x, s);
        logic [7:0] r;
        rd(8'h03, r);
        `CHK(r & 8'hEF, s)
        rd(8'h05, r);
        `CHK(r, x)
    endtask
    task automatic wrap_up();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        for (int a = 0; a < 8; a++) begin
            rd(a == 7 ? 8'h07 + rnd() % 8'hF9 : 8'(a), v);
            `CHK(v, a == 6 ? 8'hA2 : 8'h00)
        end
        wr(8'h06, 8'h01);
        wr(8'h01, 8'h20);
        rd(8'h01, v);
        wr(8'h02, 8'h0F);
        rd(8'h02, v);
        `CHK(v[3:0], 4'hF)
        for (int i = 0; i < 7; i++) begin
            d = rnd();
            tx({1'b0, d}, 1'b0, 1'b1, i < 4 ? -1 : i * 4 - 16 + (i == 6));
            `CHK(rx_irq_out, 1'b1)
            `CHK(err_irq_out, i > 3)
            chr(d, st(1'b1, 1'b0, i > 3, 1'b0));
            nop(2);
            `CHK(err_irq_out, 1'b0)
        end
        d = rnd() | 8'h01;
        tx({1'b0, d}, 1'b0, 1'b0, -1);
        chr(d, st(1'b1, 1'b0, 1'b0, 1'b1));
        tx(9'h000, 1'b0, 1'b0, -1);
        rd(8'h04, v);
        `CHK(v[1], 1'b1)
        chr(8'h00, st(1'b1, 1'b0, 1'b0, 1'b1));
        // two-clock dip must not start a frame
        arr_line_model_i.send(12'hFFF, 1, 0, 0);
        d = rnd();
        tx({1'b0, d}, 1'b0, 1'b1, -1);
        tx({1'b0, rnd()}, 1'b0, 1'b1, -1);
        `CHK(err_irq_out, 1'b1)
        chr(d, st(1'b1, 1'b1, 1'b0, 1'b0));
        wr(8'h00, 8'h12);
        tx({1'b1, d}, 1'b1, 1'b1, -1);
        rd(8'h02, v);
        `CHK(v[7], 1'b1)
        chr(d, st(1'b1, 1'b0, 1'b0, 1'b0) | {7'h00, ~^d});
        $display("test frames done");
        wr(8'h00, 8'h08);
        wr(8'h01, 8'h22);
        tx({1'b0, d & 8'h7F}, 1'b0, 1'b1, -1);
        `CHK(rx_irq_out, 1'b0)
        tx({2'b01, d[6:0]}, 1'b0, 1'b1, -1);
        `CHK(rx_irq_out, 1'b1)
        rd(8'h01, v);
        `CHK(v, 8'h20)
        chr({1'b1, d[6:0]}, st(1'b1, 1'b0, 1'b0, 1'b0));
        wr(8'h01, 8'h10);
        nop(400);
        `CHK(rx_irq_out, 1'b1)
        rd(8'h03, v);
        rd(8'h05, v);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h02);
        nop(8);
        rd(8'h01, v);
        `CHK(v[1], 1'b0)
        $display("test wakeup done");
        wt <= 1'b1;
        wr(8'h02, 8'h00);
        tx({1'b0, d}, 1'b0, 1'b1, 4);
        `CHK(err_irq_out, 1'b1)
        wt <= 1'b0;
        rd(8'h02, v);
        `CHK(v[3:0], 4'hF)
        chr(d, st(1'b1, 1'b0, 1'b1, 1'b0));
        sp <= #4000 1'b1;
        tx({1'b0, d}, 1'b0, 1'b1, -1);
        sp <= 1'b0;
        nop(40);
        rd(8'h03, v);
        `CHK(v & 8'hEF, 8'h00)
        $display("test modes done");
        for (int b = 0; b < 2; b++) begin
            tx({1'b0, d}, 1'b0, 1'b1, 4);
            rd(8'h03, v);
            br <= 1'b1;
            bce <= b[0];
            rd(8'h05, v);
            br <= 1'b0;
            rd(8'h03, v);
            `CHK(v & 8'hEF, b ? 8'h00 : st(1'b1, 1'b0, 1'b1, 1'b0))
            rd(8'h05, v);
        end
        wr(8'h02, 8'h00);
        rd(8'h02, v);
        `CHK(err_irq_out, 1'b0)
        $display("test break done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        wrap_up();
    end
endmodule
`default_nettype wire
